// [src/sfc_defs.vh]
// constants for the serial command front end
`ifndef SFC_DEFS_VH
`define SFC_DEFS_VH
`define SFC_OP_SET_WL 8'h06
`define SFC_OP_CLR_WL 8'h04
`define SFC_OP_STAT_RD 8'h05
`define SFC_OP_STAT_WR 8'h01
`define SFC_OP_MEM_RD 8'h03
`define SFC_OP_FAST_RD 8'h0B
`define SFC_OP_MEM_WR 8'h02
`define SFC_OP_SLEEP 8'hB9
`define SFC_OP_ID_RD 8'h9F
`define SFC_ADDR_W 18
`define SFC_ADDR_BYTES 3'h3
`define SFC_BIT_LAST 3'h7
`define SFC_SR_WEL 1
`define SFC_SR_BP0 2
`define SFC_SR_BP1 3
`define SFC_SR_PROTECT_PIN_ENABLE 7
`define SFC_SR_FIXED 8'h40
`define SFC_CMD_NONE 4'h0
`define SFC_CMD_SET_WL 4'h1
`define SFC_CMD_CLR_WL 4'h2
`define SFC_CMD_STAT_RD 4'h3
`define SFC_CMD_STAT_WR 4'h4
`define SFC_CMD_MEM_RD 4'h5
`define SFC_CMD_FAST_RD 4'h6
`define SFC_CMD_MEM_WR 4'h7
`define SFC_CMD_SLEEP 4'h8
`define SFC_CMD_ID_RD 4'h9
`define SFC_CMD_BAD 4'hF
`endif

// [src/sfc_fifo.v]
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/10ps
module sfc_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 8,
	parameter AW = 3
) (
	// clock and reset
	input wire clk,
	input wire nrst,
	// fill side
	input wire inValid,
	input wire [WIDTH-1:0] inData,
	output wire inReady,
	// drain side
	output wire outValid,
	output wire [WIDTH-1:0] outData,
	input wire outReady
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW:0] wrPtr_r;
	reg [AW:0] rdPtr_r;
	wire full;
	wire empty;
	assign empty = (wrPtr_r == rdPtr_r);
	assign full = (wrPtr_r[AW] != rdPtr_r[AW]) && (wrPtr_r[AW-1:0] == rdPtr_r[AW-1:0]);
	assign inReady = !full;
	assign outValid = !empty;
	assign outData = mem[rdPtr_r[AW-1:0]];
	always @(posedge clk) begin
		if (inValid && !full)
			mem[wrPtr_r[AW-1:0]] <= inData;
	end
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wrPtr_r <= {(AW+1){1'b0}};
			rdPtr_r <= {(AW+1){1'b0}};
		end else begin
			if (inValid && !full)
				wrPtr_r <= wrPtr_r + 1'b1;
			if (outReady && !empty)
				rdPtr_r <= rdPtr_r + 1'b1;
		end
	end
endmodule // sfc_fifo

// [src/sfc_spi_front.v]
// spi slave command front end: framing, opcode decode, write latch, status
`timescale 1ns/10ps
`include "sfc_defs.vh"
module sfc_spi_front #(
	parameter ADDR_W = `SFC_ADDR_W,
	parameter FIFO_DEPTH = 8
) (
	// clock and reset
	input wire clk,
	input wire nrst,
	// spi pins (asynchronous to clk)
	input wire csN,
	input wire sck,
	input wire si,
	output reg so,
	output reg soOeN,
	// write protect pin
	input wire wpN,
	// memory data to send for reads
	input wire [7:0] rdData,
	// decoded command and address
	output reg [3:0] cmdCode,
	output reg cmdValid,
	output reg [ADDR_W-1:0] memAddr,
	output reg addrValid,
	output reg spiMode3,
	// received write data stream
	output reg wrValid,
	output reg [7:0] wrData,
	input wire wrReady,
	// status and fifo back-pressure
	output reg [7:0] statusReg,
	output reg writeLatchFlag,
	output reg fifoStall
);
	localparam ST_IDLE = 3'h0;
	localparam ST_OPC = 3'h1;
	localparam ST_ADDR = 3'h2;
	localparam ST_DATA = 3'h3;
	localparam ST_DEAD = 3'h4;

	// ----------------------------------------------------------------
	// opcode decode
	// ----------------------------------------------------------------
	function [3:0] decodeOp;
		input [7:0] op;
		begin
			case (op)
				`SFC_OP_SET_WL: decodeOp = `SFC_CMD_SET_WL;
				`SFC_OP_CLR_WL: decodeOp = `SFC_CMD_CLR_WL;
				`SFC_OP_STAT_RD: decodeOp = `SFC_CMD_STAT_RD;
				`SFC_OP_STAT_WR: decodeOp = `SFC_CMD_STAT_WR;
				`SFC_OP_MEM_RD: decodeOp = `SFC_CMD_MEM_RD;
				`SFC_OP_FAST_RD: decodeOp = `SFC_CMD_FAST_RD;
				`SFC_OP_MEM_WR: decodeOp = `SFC_CMD_MEM_WR;
				`SFC_OP_SLEEP: decodeOp = `SFC_CMD_SLEEP;
				`SFC_OP_ID_RD: decodeOp = `SFC_CMD_ID_RD;
				default: decodeOp = `SFC_CMD_BAD;
			endcase
		end
	endfunction

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	reg csMeta_r, csSync_r, csPrev_r;
	reg sckMeta_r, sckSync_r, sckPrev_r;
	reg siMeta_r, siSync_r;
	reg wpMeta_r, wpSync_r;
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			csMeta_r <= 1'b1;
			csSync_r <= 1'b1;
			csPrev_r <= 1'b1;
			sckMeta_r <= 1'b0;
			sckSync_r <= 1'b0;
			sckPrev_r <= 1'b0;
			siMeta_r <= 1'b0;
			siSync_r <= 1'b0;
			wpMeta_r <= 1'b1;
			wpSync_r <= 1'b1;
		end else begin
			csMeta_r <= csN;
			csSync_r <= csMeta_r;
			csPrev_r <= csSync_r;
			sckMeta_r <= sck;
			sckSync_r <= sckMeta_r;
			sckPrev_r <= sckSync_r;
			siMeta_r <= si;
			siSync_r <= siMeta_r;
			wpMeta_r <= wpN;
			wpSync_r <= wpMeta_r;
		end
	end
	wire csFall = csPrev_r && !csSync_r;
	wire csRise = !csPrev_r && csSync_r;
	wire selected = !csSync_r;
	// mode 3 idle-high level is not an edge: only a true low-to-high counts
	wire sckRise = selected && !sckPrev_r && sckSync_r;
	wire sckFall = selected && sckPrev_r && !sckSync_r;

	// ----------------------------------------------------------------
	// shift and sequence
	// ----------------------------------------------------------------
	reg [2:0] state_r, state_nxt;
	reg [2:0] bitCnt_r;
	reg [1:0] byteCnt_r;
	reg [7:0] shIn_r;
	reg [7:0] shOut_r;
	reg [3:0] cmd_r;
	reg wel_r;
	reg [1:0] bp_r;
	reg protect_pin_enable_r;
	reg fifoValid_r;
	reg [7:0] fifoIn_r;
	wire fifoInReady;
	wire fifoOutValid;
	wire [7:0] fifoOutData;
	wire [7:0] shNext = {shIn_r[6:0], siSync_r};
	wire byteDone = sckRise && (bitCnt_r == `SFC_BIT_LAST);
	wire [7:0] statusNow = `SFC_SR_FIXED | ({7'h00, protect_pin_enable_r} << `SFC_SR_PROTECT_PIN_ENABLE)
		| ({7'h00, bp_r[1]} << `SFC_SR_BP1) | ({7'h00, bp_r[0]} << `SFC_SR_BP0)
		| ({7'h00, wel_r} << `SFC_SR_WEL);
	wire statusLocked = protect_pin_enable_r && !wpSync_r;
	wire needsAddr = (cmd_r == `SFC_CMD_MEM_RD) || (cmd_r == `SFC_CMD_FAST_RD)
		|| (cmd_r == `SFC_CMD_MEM_WR);
	wire [3:0] opNow = decodeOp(shNext);

	always @* begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: if (csFall) state_nxt = ST_OPC;
			ST_OPC: if (byteDone) begin
				if (opNow == `SFC_CMD_BAD)
					state_nxt = ST_DEAD;
				else if (opNow == `SFC_CMD_MEM_RD || opNow == `SFC_CMD_FAST_RD
					|| opNow == `SFC_CMD_MEM_WR)
					state_nxt = ST_ADDR;
				else
					state_nxt = ST_DATA;
			end
			ST_ADDR: if (byteDone && byteCnt_r == `SFC_ADDR_BYTES - 3'h1) state_nxt = ST_DATA;
			ST_DATA: state_nxt = ST_DATA;
			ST_DEAD: state_nxt = ST_DEAD;
			default: state_nxt = ST_IDLE;
		endcase
		if (csRise)
			state_nxt = ST_IDLE;
	end

	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_r <= ST_IDLE;
			bitCnt_r <= 3'h0;
			byteCnt_r <= 2'h0;
			shIn_r <= 8'h00;
			shOut_r <= 8'h00;
			cmd_r <= `SFC_CMD_NONE;
			wel_r <= 1'b0;
			bp_r <= 2'h0;
			protect_pin_enable_r <= 1'b0;
			spiMode3 <= 1'b0;
			cmdCode <= `SFC_CMD_NONE;
			cmdValid <= 1'b0;
			memAddr <= {ADDR_W{1'b0}};
			addrValid <= 1'b0;
			so <= 1'b0;
			soOeN <= 1'b1;
			fifoValid_r <= 1'b0;
			fifoIn_r <= 8'h00;
			fifoStall <= 1'b0;
		end else begin
			state_r <= state_nxt;
			cmdValid <= 1'b0;
			addrValid <= 1'b0;
			if (fifoValid_r && fifoInReady)
				fifoValid_r <= 1'b0;
			fifoStall <= fifoValid_r && !fifoInReady;
			if (csFall) begin
				spiMode3 <= sckSync_r;
				bitCnt_r <= 3'h0;
				byteCnt_r <= 2'h0;
				cmd_r <= `SFC_CMD_NONE;
				memAddr <= {ADDR_W{1'b0}};
			end
			if (csRise) begin
				soOeN <= 1'b1;
				if (cmd_r == `SFC_CMD_CLR_WL || cmd_r == `SFC_CMD_STAT_WR
					|| cmd_r == `SFC_CMD_MEM_WR)
					wel_r <= 1'b0;
			end
			if (sckRise && (state_r == ST_OPC || state_r == ST_ADDR || state_r == ST_DATA)) begin
				shIn_r <= shNext;
				bitCnt_r <= bitCnt_r + 3'h1;
			end
			if (byteDone && state_r == ST_OPC) begin
				cmd_r <= opNow;
				cmdCode <= opNow;
				cmdValid <= 1'b1;
				if (opNow == `SFC_CMD_SET_WL)
					wel_r <= 1'b1;
				if (opNow == `SFC_CMD_STAT_RD)
					shOut_r <= statusNow;
			end
			if (byteDone && state_r == ST_ADDR) begin
				memAddr <= {memAddr[ADDR_W-9:0], shNext};
				byteCnt_r <= byteCnt_r + 2'h1;
				if (byteCnt_r == `SFC_ADDR_BYTES - 3'h1) begin
					addrValid <= 1'b1;
					if (cmd_r == `SFC_CMD_MEM_RD || cmd_r == `SFC_CMD_FAST_RD)
						shOut_r <= rdData;
				end
			end
			if (byteDone && state_r == ST_DATA) begin
				if (cmd_r == `SFC_CMD_STAT_WR && wel_r && !statusLocked) begin
					// latch flag in the written byte is ignored
					bp_r <= {shNext[`SFC_SR_BP1], shNext[`SFC_SR_BP0]};
					protect_pin_enable_r <= shNext[`SFC_SR_PROTECT_PIN_ENABLE];
				end
				if (cmd_r == `SFC_CMD_MEM_WR && wel_r) begin
					// byte handed on at once: no busy phase
					fifoValid_r <= 1'b1;
					fifoIn_r <= shNext;
				end
				if (cmd_r == `SFC_CMD_MEM_RD || cmd_r == `SFC_CMD_FAST_RD)
					shOut_r <= rdData;
				if (needsAddr)
					memAddr <= memAddr + 1'b1;
			end
			if (sckFall && state_r == ST_DATA && (cmd_r == `SFC_CMD_STAT_RD
				|| cmd_r == `SFC_CMD_MEM_RD || cmd_r == `SFC_CMD_FAST_RD)) begin
				so <= shOut_r[3'h7 - bitCnt_r];
				soOeN <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// write data buffer and output registers
	// ----------------------------------------------------------------
	sfc_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .AW(3)) uFifo (
		.clk(clk),
		.nrst(nrst),
		.inValid(fifoValid_r),
		.inData(fifoIn_r),
		.inReady(fifoInReady),
		.outValid(fifoOutValid),
		.outData(fifoOutData),
		.outReady(wrReady && !wrValid)
	);
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wrValid <= 1'b0;
			wrData <= 8'h00;
			statusReg <= `SFC_SR_FIXED;
			writeLatchFlag <= 1'b0;
		end else begin
			if (wrValid)
				wrValid <= 1'b0;
			else if (fifoOutValid && wrReady) begin
				wrValid <= 1'b1;
				wrData <= fifoOutData;
			end
			statusReg <= statusNow;
			writeLatchFlag <= wel_r;
		end
	end
endmodule // sfc_spi_front

// [bench/sfc_spi_front_asserts.sv]
// assertions on the spi command front end ports
`timescale 1ns/10ps
module sfc_spi_front_asserts #(
	parameter ADDR_W = 18
) (
	// clock and reset
	input wire clk,
	input wire nrst,
	// spi pins
	input wire csN,
	input wire sck,
	input wire si,
	input wire so,
	input wire soOeN,
	input wire wpN,
	input wire [7:0] rdData,
	// command outputs
	input wire [3:0] cmdCode,
	input wire cmdValid,
	input wire [ADDR_W-1:0] memAddr,
	input wire addrValid,
	input wire spiMode3,
	// write stream and status
	input wire wrValid,
	input wire [7:0] wrData,
	input wire wrReady,
	input wire [7:0] statusReg,
	input wire writeLatchFlag,
	input wire fifoStall
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	sequence s_set_cmd;
		cmdValid && cmdCode == 4'h1;
	endsequence
	sequence s_idle;
		csN [*6];
	endsequence
	a_oe_idle_off: assert property (s_idle |-> soOeN) else $error("so driven while idle");
	a_cmd_once: assert property (cmdValid |=> !cmdValid [*8]) else $error("second opcode");
	a_addr_cmd: assert property (addrValid |-> cmdCode inside {4'h5, 4'h6, 4'h7})
		else $error("address on wrong command");
	a_latch_set: assert property (s_set_cmd |-> ##[0:1] writeLatchFlag) else $error("no set");
	a_latch_only: assert property ($rose(writeLatchFlag) |-> cmdCode == 4'h1)
		else $error("latch set by other command");
	a_latch_clear: assert property ($fell(writeLatchFlag) |-> csN && cmdCode inside {4'h2, 4'h4, 4'h7})
		else $error("latch cleared wrongly");
	a_flag_mirror: assert property (writeLatchFlag != statusReg[1] |=> writeLatchFlag == statusReg[1])
		else $error("flag not mirrored");
	a_fixed_bits: assert property (statusReg[6:4] == 3'b100 && !statusReg[0])
		else $error("fixed status bits");
	a_drive_reads: assert property (!soOeN |-> cmdCode inside {4'h3, 4'h5, 4'h6})
		else $error("so driven on non read");
	a_so_on_fall: assert property ($changed(so) && !soOeN |-> !sck) else $error("so not on fall");
	a_write_cmd: assert property (wrValid |-> cmdCode == 4'h7 && wrReady)
		else $error("write byte out of place");
endmodule // sfc_spi_front_asserts
bind sfc_spi_front sfc_spi_front_asserts #(.ADDR_W(ADDR_W)) i_sfc_spi_front_asserts (
	.clk(clk), .nrst(nrst), .csN(csN), .sck(sck), .si(si), .so(so), .soOeN(soOeN),
	.wpN(wpN), .rdData(rdData), .cmdCode(cmdCode), .cmdValid(cmdValid), .memAddr(memAddr),
	.addrValid(addrValid), .spiMode3(spiMode3), .wrValid(wrValid), .wrData(wrData),
	.wrReady(wrReady), .statusReg(statusReg), .writeLatchFlag(writeLatchFlag),
	.fifoStall(fifoStall));

// [bench/sfc_spi_master.sv]
// spi master model: select, clock and data out, serial out sampled
`timescale 1ns/10ps
module sfc_spi_master (
	// spi pins
	output logic csN,
	output logic sck,
	output logic si,
	input wire so,
	input wire soOeN
);
	logic mode3 = 1'b0;
	initial begin
		csN = 1'b1;
		sck = 1'b0;
		si = 1'b0;
	end
	// clock idles at the mode level before select falls
	task automatic start(input logic m3);
		mode3 = m3;
		sck = m3;
		#100;
		csN = 1'b0;
		#100;
	endtask
	// msb first; data set on the low phase, taken at the rise
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			sck = 1'b0;
			si = tx[i];
			#62.5;
			sck = 1'b1;
			rx[i] = soOeN ? 1'bz : so;
			#62.5;
		end
	endtask
	task automatic stop;
		#62.5;
		sck = mode3;
		#62.5;
		csN = 1'b1;
		si = ~si;
		#200;
	endtask
endmodule // sfc_spi_master

// [bench/tb_top.sv]
// self-checking bench for the spi command front end
`timescale 1ns/10ps
module tb_top;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic wpN = 1'b1;
	logic wrReady = 1'b1;
	logic [7:0] rdData = 8'h96;
	wire csN, sck, si, so, soOeN, cmdValid, addrValid, spiMode3, wrValid, writeLatchFlag, fifoStall;
	wire [3:0] cmdCode;
	wire [17:0] memAddr;
	wire [7:0] wrData, statusReg;
	logic [7:0] rx;
	logic [3:0] lastCmd;
	logic [17:0] lastAddr;
	logic [7:0] got [0:15];
	logic [7:0] ops [0:9] = '{8'h06, 8'h04, 8'h05, 8'h01, 8'h03, 8'h0B, 8'h02, 8'hB9, 8'h9F, 8'hFF};
	logic [3:0] codes [0:9] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hF};
	int nGot = 0;
	int n_fail = 0;
	int n_checks = 0;
	always #4 clk = ~clk;
	sfc_spi_front i_sfc_spi_front (.clk(clk), .nrst(nrst), .csN(csN), .sck(sck), .si(si),
		.so(so), .soOeN(soOeN), .wpN(wpN), .rdData(rdData), .cmdCode(cmdCode),
		.cmdValid(cmdValid), .memAddr(memAddr), .addrValid(addrValid), .spiMode3(spiMode3),
		.wrValid(wrValid), .wrData(wrData), .wrReady(wrReady), .statusReg(statusReg),
		.writeLatchFlag(writeLatchFlag), .fifoStall(fifoStall));
	sfc_spi_master i_sfc_spi_master (.csN(csN), .sck(sck), .si(si), .so(so), .soOeN(soOeN));
	always @(posedge clk) begin
		if (cmdValid === 1'b1) lastCmd <= cmdCode;
		if (addrValid === 1'b1) lastAddr <= memAddr;
		if (wrValid === 1'b1 && wrReady === 1'b1) begin
			got[nGot] <= wrData;
			nGot <= nGot + 1;
		end
	end
	task automatic chk(input logic [31:0] a, input logic [31:0] b, input string m);
		n_checks++;
		if (a !== b) begin
			n_fail++;
			$display("mismatch at %0t: %s", $time, m);
		end
	endtask
	task automatic frame(input logic m3, input logic [7:0] bytes[$]);
		i_sfc_spi_master.start(m3);
		foreach (bytes[k]) i_sfc_spi_master.xfer(bytes[k], rx);
		i_sfc_spi_master.stop();
	endtask
	task automatic t_decode;
		chk(statusReg, 8'h40, "status at reset");
		chk(writeLatchFlag, 1'b0, "latch at reset");
		for (int i = 0; i < 10; i++) begin
			frame(i[0], '{ops[i]});
			chk(lastCmd, codes[i], "decode");
			chk(spiMode3, i[0], "mode");
		end
		frame(1'b1, '{8'hFF, 8'h05});
		chk(rx, 8'bz, "bad opcode drove so");
		$display("test decode done");
	endtask
	task automatic t_status;
		frame(1'b0, '{8'h06});
		chk(statusReg[1], 1'b1, "latch flag");
		frame(1'b1, '{8'h01, 8'h8F});
		chk(statusReg, 8'hCC, "status write");
		frame(1'b0, '{8'h01, 8'h00});
		chk(statusReg, 8'hCC, "write without latch");
		frame(1'b0, '{8'h05, 8'h00});
		chk(rx, 8'hCC, "status read");
		@(posedge clk) #1 wpN = 1'b0;
		frame(1'b0, '{8'h06});
		frame(1'b0, '{8'h01, 8'h00});
		chk(statusReg[7:2], 6'h33, "pin protect");
		@(posedge clk) #1 wpN = 1'b1;
		frame(1'b0, '{8'h06});
		frame(1'b0, '{8'h01, 8'h00});
		chk(statusReg, 8'h40, "unprotected write");
		frame(1'b0, '{8'h06});
		frame(1'b0, '{8'h04});
		chk(writeLatchFlag, 1'b0, "latch clear");
		$display("test status done");
	endtask
	task automatic t_memory;
		frame(1'b0, '{8'h03, 8'h00, 8'h00, 8'h40, 8'h00});
		chk(lastAddr, 18'h0_0040, "read address");
		chk(rx, 8'h96, "read data");
		@(posedge clk) #1 wrReady = 1'b0;
		frame(1'b0, '{8'h06});
		frame(1'b1, '{8'h02, 8'hFE, 8'h12, 8'h34, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15,
			8'h16, 8'h17, 8'h18});
		chk(lastAddr, 18'h2_1234, "address width");
		chk(fifoStall, 1'b1, "fifo full");
		chk(nGot, 0, "stalled sink");
		chk(writeLatchFlag, 1'b0, "latch after write");
		@(posedge clk) #1 wrReady = 1'b1;
		repeat (30) @(posedge clk);
		chk(nGot, 9, "drained count");
		for (int i = 0; i < 9; i++) chk(got[i], 8'h10 + i, "write data");
		$display("test memory done");
	endtask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge clk);
		#1 nrst = 1'b1;
		repeat (4) @(posedge clk);
		t_decode();
		t_status();
		t_memory();
		end_of_test();
	end
	initial begin
		#600000;
		n_fail++;
		end_of_test();
	end
endmodule // tb_top
